// [verilog/framer_event_consts.vh]
// constants for the framer event status and interrupt block
// assumes a 40 mhz core clock and byte-wide register port
`ifndef FRAMER_EVENT_CONSTS_VH
`define FRAMER_EVENT_CONSTS_VH
`define COND_STATUS_ADDR      8'h1a
`define COND_MASK_ADDR        8'h1b
`define EVENT_STATUS_ADDR     8'h1c
`define EVENT_MASK_ADDR       8'h1d
`define STATUS_RESET          8'h00
`define MASK_RESET            8'h00
`define BIT_LINK_IDENT        2
`define BIT_RX_CLK_LOST       3
`define BIT_TX_CLK_LOST       4
`define BIT_LOOP_UP           5
`define BIT_LOOP_DOWN         6
`define BIT_SPARE             7
`define BIT_RX_ALIGN          0
`define BIT_RX_CRC_MF         1
`define BIT_RX_MF             2
`define BIT_TX_ALIGN          3
`define BIT_TX_MF             4
`define BIT_SIG_ZEROS         5
`define BIT_SIG_ONES          6
`define BIT_AIS_CI            7
`define CLK_PERIOD_NS         25
`define CHANNEL_TIME_NS       3900
`define CHANNEL_TIME_CYCLES   ((`CHANNEL_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// [verilog/line_clock_watch.v]
// watches one line clock for activity, flags loss after one channel time
// assumes the line clock is already synchronous to core_clk
`timescale 1ns/10ps
`include "framer_event_consts.vh"
module line_clock_watch #(
  parameter LIMIT = `CHANNEL_TIME_CYCLES
) (
  input  wire core_clk,
  input  wire rst_n,
  input  wire line_clk,
  output reg  clock_lost
);
  reg        last_reg;
  reg [15:0] idle_reg;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      last_reg   <= 1'b0;
      idle_reg   <= 16'h0000;
      clock_lost <= 1'b0;
    end else begin
      last_reg <= line_clk;
      if (line_clk != last_reg) begin
        idle_reg   <= 16'h0000;
        clock_lost <= 1'b0;
      end else if (idle_reg >= LIMIT[15:0] - 16'h0001) begin
        clock_lost <= 1'b1;
      end else begin
        idle_reg <= idle_reg + 16'h0001;
      end
    end
  end
endmodule // line_clock_watch

// [verilog/framer_event_status_irq.v]
// What this block does
// - condition mask 0 blocks, 1 interrupts on both edges of each condition
// - e1: receive align frame event at each align frame start
// - e1: crc-4 multiframe event on boundaries, free-running if crc-4 off
// - e1: receive multiframe event every multiframe, cas or not
// - t1: receive and transmit multiframe events, 1.5ms d4, 3ms esf
// - e1: transmit align frame event at each align frame start
// - e1: transmit multiframe event every transmit multiframe
// - e1: all-zeros event when slot 16 zero for a whole multiframe
// - e1: all-ones event when slot 16 has under three zeros in 16 frames
// - t1: ais-ci event when receiver reports the ais-ci pattern
// - event mask bit 0 masks, 1 enables the matching event
// - event flags latch until the host reads the status register
// - clock lost when no line clock transition for one channel time
//
// file: event/condition status, masks and interrupt of one framer channel
// assumes frame/multiframe strobes come from the framer, synchronous to core_clk
`timescale 1ns/10ps
`include "framer_event_consts.vh"
module framer_event_status_irq #(
  parameter CLK_LIMIT = `CHANNEL_TIME_CYCLES
) (
  input  wire       core_clk,
  input  wire       rst_n,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  output reg        irq,
  input  wire       e1_mode,
  input  wire       esf_mode,
  input  wire       crc4_enable,
  input  wire       link_ident_detected,
  input  wire       rx_line_clock_in,
  input  wire       tx_line_clock_in,
  input  wire       loop_up_code_seen,
  input  wire       loop_down_code_seen,
  input  wire       spare_code_seen,
  input  wire       rx_frame_start,
  input  wire       rx_align_frame,
  input  wire       rx_crc_mf_start,
  input  wire       rx_mf_start,
  input  wire       tx_frame_start,
  input  wire       tx_align_frame,
  input  wire       tx_mf_start,
  input  wire       ts16_byte_valid,
  input  wire [7:0] ts16_byte,
  input  wire       ais_ci_detected,
  output reg        rx_clock_lost,
  output reg        tx_clock_lost
);
  reg  [7:0] event_status_reg;
  reg  [7:0] event_status_next;
  reg  [7:0] event_mask_reg;
  reg  [7:0] event_mask_next;
  reg  [7:0] cond_status_reg;
  reg  [7:0] cond_status_next;
  reg  [7:0] cond_mask_reg;
  reg  [7:0] cond_mask_next;
  reg  [7:0] cond_prev_reg;

  reg  [4:0] crc_frame_reg;
  reg  [4:0] crc_frame_next;
  reg        zeros_ok_reg;
  reg        zeros_ok_next;
  reg  [4:0] ones_frames_reg;
  reg  [4:0] ones_frames_next;
  reg  [4:0] ones_zeros_reg;
  reg  [4:0] ones_zeros_next;

  reg  [7:0] rdata_next;
  reg        irq_next;
  reg  [7:0] event_set;
  reg  [7:0] cond_now;
  reg  [7:0] cond_edge;
  reg  [3:0] byte_zeros;
  reg  [4:0] zero_sum;
  reg        status_read;
  reg        cond_clear;
  wire       rx_lost_w;
  wire       tx_lost_w;

  function [3:0] count_zeros;
    input [7:0] b;
    integer k;
    begin
      count_zeros = 4'h0;
      for (k = 0; k < 8; k = k + 1) begin
        count_zeros = count_zeros + {3'b000, ~b[k]};
      end
    end
  endfunction

  // one place for address compares, shared by writes, reads and clear-on-read
  function addr_hit;
    input [7:0] addr;
    input       strobe;
    input [7:0] target;
    begin
      addr_hit = strobe & (addr == target);
    end
  endfunction

  // the all-ones window only needs to know whether three zeros were reached
  function [4:0] sat_three;
    input [4:0] n;
    begin
      sat_three = (n > 5'd3) ? 5'd3 : n;
    end
  endfunction

  line_clock_watch #(.LIMIT(CLK_LIMIT)) rx_watch (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .line_clk   (rx_line_clock_in),
    .clock_lost (rx_lost_w)
  );

  line_clock_watch #(.LIMIT(CLK_LIMIT)) tx_watch (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .line_clk   (tx_line_clock_in),
    .clock_lost (tx_lost_w)
  );

  // condition levels and their edges
  always @* begin
    cond_now                   = 8'h00;
    cond_now[`BIT_LINK_IDENT]  = link_ident_detected;
    cond_now[`BIT_RX_CLK_LOST] = rx_lost_w;
    cond_now[`BIT_TX_CLK_LOST] = tx_lost_w;
    cond_now[`BIT_LOOP_UP]     = loop_up_code_seen;
    cond_now[`BIT_LOOP_DOWN]   = loop_down_code_seen;
    cond_now[`BIT_SPARE]       = spare_code_seen;
    // both edges of a condition count as events
    cond_edge                  = cond_now ^ cond_prev_reg;
  end

  always @* begin
    byte_zeros = count_zeros(ts16_byte);
    zero_sum   = ones_zeros_reg + {1'b0, byte_zeros};
    event_set  = 8'h00;
    event_set[`BIT_RX_ALIGN] = e1_mode & rx_frame_start & rx_align_frame;
    // without crc-4 this block's own 16-frame count stands in for the boundary
    event_set[`BIT_RX_CRC_MF] = e1_mode & (crc4_enable ? rx_crc_mf_start
                               : (rx_frame_start & (crc_frame_reg == 5'd0)));
    event_set[`BIT_RX_MF]    = rx_mf_start;
    event_set[`BIT_TX_ALIGN] = e1_mode & tx_frame_start & tx_align_frame;
    event_set[`BIT_TX_MF]    = tx_mf_start;
    event_set[`BIT_SIG_ZEROS] = e1_mode & rx_mf_start & zeros_ok_reg;
    event_set[`BIT_SIG_ONES]  = e1_mode & ts16_byte_valid &
                                (ones_frames_reg == 5'd15) & (zero_sum < 5'd3);
    event_set[`BIT_AIS_CI]    = ~e1_mode & ais_ci_detected;
  end

  // strobe-qualified decodes used by the flag updates
  always @* begin
    status_read = addr_hit(reg_addr, reg_rd, `EVENT_STATUS_ADDR);
    cond_clear  = addr_hit(reg_addr, reg_wr, `COND_STATUS_ADDR);
  end

  always @* begin
    // read clears event flags; a same-cycle set survives
    if (status_read) begin
      event_status_next = event_set;
    end else begin
      event_status_next = event_status_reg | event_set;
    end
    // write-one-to-clear; an edge in the same cycle wins
    if (cond_clear) begin
      cond_status_next = (cond_status_reg & ~reg_wdata) | cond_edge;
    end else begin
      cond_status_next = cond_status_reg | cond_edge;
    end
  end

  // the event status register is read-only, writes to it fall through
  always @* begin
    event_mask_next = event_mask_reg;
    cond_mask_next  = cond_mask_reg;
    if (addr_hit(reg_addr, reg_wr, `EVENT_MASK_ADDR)) begin
      event_mask_next = reg_wdata;
    end else if (addr_hit(reg_addr, reg_wr, `COND_MASK_ADDR)) begin
      cond_mask_next = reg_wdata;
    end
  end

  always @* begin
    crc_frame_next   = crc_frame_reg;
    zeros_ok_next    = zeros_ok_reg;
    ones_frames_next = ones_frames_reg;
    ones_zeros_next  = ones_zeros_reg;
    if (rx_frame_start) begin
      crc_frame_next = (crc_frame_reg == 5'd15) ? 5'd0 : crc_frame_reg + 5'd1;
    end
    // all-zeros tracker restarts at each multiframe
    if (rx_mf_start) begin
      zeros_ok_next = 1'b1;
    end else if (ts16_byte_valid && ts16_byte != 8'h00) begin
      zeros_ok_next = 1'b0;
    end
    // fixed 16-frame windows; a sliding window would need 16 stored counts
    if (ts16_byte_valid) begin
      if (ones_frames_reg == 5'd15) begin
        ones_frames_next = 5'd0;
        ones_zeros_next  = 5'd0;
      end else begin
        ones_frames_next = ones_frames_reg + 5'd1;
        ones_zeros_next  = sat_three(zero_sum);
      end
    end
  end

  // unmapped addresses and idle cycles read as zero
  always @* begin
    if (addr_hit(reg_addr, reg_rd, `EVENT_STATUS_ADDR)) begin
      rdata_next = event_status_reg;
    end else if (addr_hit(reg_addr, reg_rd, `EVENT_MASK_ADDR)) begin
      rdata_next = event_mask_reg;
    end else if (addr_hit(reg_addr, reg_rd, `COND_STATUS_ADDR)) begin
      rdata_next = cond_status_reg;
    end else if (addr_hit(reg_addr, reg_rd, `COND_MASK_ADDR)) begin
      rdata_next = cond_mask_reg;
    end else begin
      rdata_next = 8'h00;
    end
  end

  // bits 0 and 1 of the condition register belong to other alarms, not here
  always @* begin
    irq_next = |(event_status_reg & event_mask_reg) |
               |(cond_status_reg & cond_mask_reg & 8'hfc);
  end

  // event flags and their mask
  always @(posedge core_clk) begin
    if (!rst_n) begin
      event_status_reg <= `STATUS_RESET;
      event_mask_reg   <= `MASK_RESET;
    end else begin
      event_status_reg <= event_status_next;
      event_mask_reg   <= event_mask_next;
    end
  end

  // condition flags, their mask and the last sampled levels
  always @(posedge core_clk) begin
    if (!rst_n) begin
      cond_status_reg  <= `STATUS_RESET;
      cond_mask_reg    <= `MASK_RESET;
      cond_prev_reg    <= 8'h00;
    end else begin
      cond_status_reg  <= cond_status_next;
      cond_mask_reg    <= cond_mask_next;
      cond_prev_reg    <= cond_now;
    end
  end

  // frame trackers for the free-running crc boundary and slot-16 alarms
  always @(posedge core_clk) begin
    if (!rst_n) begin
      crc_frame_reg    <= 5'd0;
      zeros_ok_reg     <= 1'b1;
      ones_frames_reg  <= 5'd0;
      ones_zeros_reg   <= 5'd0;
    end else begin
      crc_frame_reg    <= crc_frame_next;
      zeros_ok_reg     <= zeros_ok_next;
      ones_frames_reg  <= ones_frames_next;
      ones_zeros_reg   <= ones_zeros_next;
    end
  end

  // clock-loss outputs come from flops, one cycle behind the watchers
  always @(posedge core_clk) begin
    if (!rst_n) begin
      rx_clock_lost    <= 1'b0;
      tx_clock_lost    <= 1'b0;
    end else begin
      rx_clock_lost    <= rx_lost_w;
      tx_clock_lost    <= tx_lost_w;
    end
  end

  // read data stands for the one cycle after the strobe
  always @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata        <= 8'h00;
    end else begin
      reg_rdata        <= rdata_next;
    end
  end

  // interrupt lags the flags by one cycle so it leaves a flop
  always @(posedge core_clk) begin
    if (!rst_n) begin
      irq              <= 1'b0;
    end else begin
      irq              <= irq_next;
    end
  end
endmodule // framer_event_status_irq

// [sim/event_irq_chk.sv]
// checker: interrupt, read data and clock-loss timing at the block's ports
// assumes it is bound into framer_event_status_irq, one clock domain
`timescale 1ns/10ps
module event_irq_chk #(
  parameter CLK_LIMIT = 8
) (
  input wire       core_clk,
  input wire       rst_n,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire       irq,
  input wire       e1_mode,
  input wire       rx_line_clock_in,
  input wire       rx_frame_start,
  input wire       rx_align_frame,
  input wire       rx_mf_start,
  input wire       tx_mf_start,
  input wire       loop_up_code_seen,
  input wire       rx_clock_lost,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  reg [7:0] ev_m, cd_m;
  reg [9:0] quiet;
  // mask shadows let irq be judged without looking inside
  always @(posedge core_clk) begin
    ev_m <= !rst_n ? 8'h00 : (reg_wr && reg_addr == 8'h1d) ? reg_wdata : ev_m;
    cd_m <= !rst_n ? 8'h00 : (reg_wr && reg_addr == 8'h1b) ? reg_wdata : cd_m;
    quiet <= (!rst_n || !$stable(rx_line_clock_in)) ? 10'h000 : quiet + {9'h000, quiet != 10'h3ff};
  end
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  reset_quiet_a: assert property ($rose(rst_n) |-> !irq && !rx_clock_lost)
    else $error("outputs not clear after reset");
  masked_quiet_a: assert property ((ev_m | cd_m | $past(ev_m) | $past(cd_m)) == 8'h00 |-> !irq)
    else $error("irq high with all sources masked");
  rx_align_a: assert property (e1_mode && ev_m[0] && rx_frame_start && rx_align_frame |-> ##[1:3] irq)
    else $error("align frame event gave no irq");
  mf_irq_a: assert property (ev_m[2] && rx_mf_start || ev_m[4] && tx_mf_start |-> ##[1:3] irq)
    else $error("multiframe event gave no irq");
  cond_edge_a: assert property (cd_m[5] && $changed(loop_up_code_seen) |-> ##[1:4] irq)
    else $error("condition edge gave no irq");
  irq_fall_a: assert property ($fell(irq) |-> $past(reg_rd) || $past(reg_rd, 2) || $past(reg_wr) || $past(reg_wr, 2))
    else $error("irq dropped without host access");
  clk_lost_a: assert property (quiet > CLK_LIMIT + 3 |-> rx_clock_lost)
    else $error("quiet receive clock not flagged");
  clk_back_a: assert property ($changed(rx_line_clock_in) |-> ##[1:4] !rx_clock_lost)
    else $error("clock loss held after transition");
  cover property (reg_rd && reg_addr == 8'h1c && irq);
  cover property ($rose(rx_clock_lost));
  cover property ($fell(irq));
endmodule // event_irq_chk
bind framer_event_status_irq event_irq_chk #(.CLK_LIMIT(CLK_LIMIT)) chk (.*);

// [sim/host_model.sv]
// host side of the register port: one-cycle write and read strobes
// assumes read data is registered and stands only in the cycle after the strobe
`timescale 1ns/10ps
module host_model (
  input  wire       core_clk,
  input  wire [7:0] reg_rdata,
  output reg  [7:0] reg_addr = 8'h00,
  output reg  [7:0] reg_wdata = 8'h00,
  output reg        reg_wr = 1'b0,
  output reg        reg_rd = 1'b0
);
  task wr(input [7:0] a, input [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // data taken at the edge that closes the cycle in which it stands
  task rd(input [7:0] a, output [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    v = reg_rdata;
  endtask
endmodule // host_model

// [sim/tb.sv]
// testbench: registers, events, conditions and clock loss of one channel
// assumes host_model drives the register port; the bench drives framer strobes
`timescale 1ns/10ps
module tb;
  reg core_clk = 0, rst_n = 0, e1_mode = 1, esf_mode = 0, crc4_enable = 1, run = 1;
  reg link_ident_detected = 0, loop_up_code_seen = 0, loop_down_code_seen = 0, spare_code_seen = 0;
  reg rx_frame_start = 0, rx_align_frame = 0, rx_crc_mf_start = 0, rx_mf_start = 0;
  reg tx_frame_start = 0, tx_align_frame = 0, tx_mf_start = 0, ts16_byte_valid = 0;
  reg ais_ci_detected = 0, rx_line_clock_in = 0, tx_line_clock_in = 0;
  reg [7:0] ts16_byte = 8'h00, d;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, irq, rx_clock_lost, tx_clock_lost;
  integer failures = 0, comparisons = 0, i;
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (run) {rx_line_clock_in, tx_line_clock_in} <= ~{rx_line_clock_in, tx_line_clock_in};
  framer_event_status_irq #(.CLK_LIMIT(8)) dut (.*);
  host_model host (.*);
  task test_done;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input [63:0] n, input [7:0] e, input [7:0] g);
    comparisons = comparisons + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("[FAIL] %0s exp %h got %h", n, e, g);
    end
  endtask
  task rchk(input [7:0] a, input [7:0] e, input [7:0] m);
    host.rd(a, d);
    chk("register", e, d & m);
  endtask
  // bounded wait; a level never reached ends the run
  task wirq(input e);
    for (i = 0; i < 8 && irq !== e; i = i + 1) @(posedge core_clk);
    chk("irq", {7'h00, e}, {7'h00, irq});
    if (irq !== e) test_done;
  endtask
  task frames(input integer n, input [7:0] b);
    repeat (n) begin
      @(posedge core_clk);
      {rx_frame_start, tx_frame_start, ts16_byte_valid, ts16_byte} <= {3'h7, b};
      @(posedge core_clk);
      {rx_frame_start, tx_frame_start, ts16_byte_valid} <= 3'h0;
    end
  endtask
  task strobe(input [3:0] w);
    @(posedge core_clk);
    {rx_crc_mf_start, rx_mf_start, tx_mf_start, ais_ci_detected} <= w;
    @(posedge core_clk);
    {rx_crc_mf_start, rx_mf_start, tx_mf_start, ais_ci_detected} <= 4'h0;
  endtask
  task s_regs;
    for (i = 8'h1a; i < 8'h1e; i = i + 1) rchk(i, 8'h00, 8'hff);
    rchk(8'h3f, 8'h00, 8'hff);
    host.wr(8'h1d, 8'ha5);
    rchk(8'h1d, 8'ha5, 8'hff);
    host.wr(8'h1b, 8'hfc);
    rchk(8'h1b, 8'hfc, 8'hfc);
    host.wr(8'h1c, 8'hff);
    rchk(8'h1c, 8'h00, 8'hff);
    host.wr(8'h1d, 8'h00);
    host.wr(8'h1b, 8'h00);
  endtask
  task s_events;
    {rx_align_frame, tx_align_frame} <= 2'b11;
    frames(1, 8'h55);
    strobe(4'he);
    wirq(0);
    rchk(8'h1c, 8'h1f, 8'h1f);
    rchk(8'h1c, 8'h00, 8'h1f);
    host.wr(8'h1d, 8'h15);
    frames(1, 8'h55);
    wirq(1);
    host.rd(8'h1c, d);
    wirq(0);
    {rx_align_frame, tx_align_frame} <= 2'b00;
    strobe(4'h4);
    wirq(1);
    host.wr(8'h1d, 8'h00);
    crc4_enable <= 0;
    rchk(8'h1c, 8'h04, 8'hff);
    frames(16, 8'h55);
    rchk(8'h1c, 8'h02, 8'h07);
    strobe(4'h4);
    frames(16, 8'h00);
    strobe(4'h4);
    rchk(8'h1c, 8'h20, 8'h60);
    frames(32, 8'hff);
    rchk(8'h1c, 8'h40, 8'h40);
    {e1_mode, esf_mode} <= 2'b01;
    strobe(4'h7);
    rchk(8'h1c, 8'h94, 8'h94);
  endtask
  task s_cond;
    host.wr(8'h1b, 8'h20);
    loop_up_code_seen <= 1;
    wirq(1);
    host.wr(8'h1a, 8'h20);
    wirq(0);
    loop_up_code_seen <= 0;
    wirq(1);
    host.wr(8'h1b, 8'h00);
    wirq(0);
    {link_ident_detected, loop_down_code_seen, spare_code_seen} <= 3'h7;
    rchk(8'h1a, 8'he4, 8'he4);
    run <= 0;
    repeat (14) @(posedge core_clk);
    chk("lost", 8'h03, {6'h00, rx_clock_lost, tx_clock_lost});
    rchk(8'h1a, 8'h18, 8'h18);
    run <= 1;
    repeat (4) @(posedge core_clk);
    chk("lost", 8'h00, {6'h00, rx_clock_lost, tx_clock_lost});
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1;
    s_regs;
    s_events;
    s_cond;
    test_done;
  end
endmodule // tb
